// [wbl_pkg.sv]
// Shared constants for the colour table stage: control register layout,
// pages, pixel lane layout and the two-wire slave state codes.
// Assumes every design file imports the whole package in its header.
`default_nettype none

package wbl_pkg;

   // Pixel layout: red in the top byte, blue in the bottom byte
   localparam int SUB_W       = 8;
   localparam int COLOURS     = 3;
   localparam int PIX_W       = SUB_W * COLOURS;
   localparam int LUT_DEPTH   = 256;
   localparam int DITH_W      = 6;
   localparam int FIFO_DEPTH  = 8;

   // Control register and its fields
   localparam logic [7:0] CTRL_ADDR    = 8'h2a;
   localparam logic [7:0] CTRL_RST     = 8'h00;
   localparam logic [7:0] CTRL_WMASK   = 8'hf0;
   localparam int         PAGE_MSB     = 7;
   localparam int         PAGE_LSB     = 6;
   localparam int         EN_BIT       = 5;
   localparam int         RELOAD_BIT   = 4;

   // Page encodings
   localparam logic [1:0] PAGE_CFG     = 2'h0;
   localparam logic [1:0] PAGE_RED     = 2'h1;
   localparam logic [1:0] PAGE_GREEN   = 2'h2;
   localparam logic [1:0] PAGE_BLUE    = 2'h3;

   // Slave addresses; values are arbitrary defaults
   localparam logic [6:0] DEV_ADDR     = 7'h2c;
   localparam logic [6:0] CFG_ALT_ADDR = 7'h2d;

   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [7:0] ZERO_BYTE     = 8'h00;

   typedef enum logic [3:0] {
      ST_IDLE     = 4'b0000,
      ST_ADDR     = 4'b0001,
      ST_ADDR_ACK = 4'b0010,
      ST_REG      = 4'b0011,
      ST_REG_ACK  = 4'b0100,
      ST_WDATA    = 4'b0101,
      ST_WDAT_ACK = 4'b0110,
      ST_RDATA    = 4'b0111,
      ST_RDAT_ACK = 4'b1000
   } wbl_i2c_state_t;

endpackage

`default_nettype wire

// [wbl_fifo.sv]
// Pixel FIFO with valid/ready on both sides and registered full/empty.
// Assumes one clock; the reader may stall so the FIFO really fills.
`default_nettype none

module wbl_fifo
   import wbl_pkg::*;
#(
   parameter int WIDTH = 24,
   parameter int DEPTH = 8
)
(
   input  wire logic             core_clk_in,
   input  wire logic             rst_b_in,
   input  wire logic             in_valid_in,
   input  wire logic [WIDTH-1:0] in_data_in,
   output logic                  in_ready_out,
   output logic                  out_valid_out,
   output logic      [WIDTH-1:0] out_data_out,
   input  wire logic             out_ready_in
);

   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0]    wr_ptr_r;
   logic [AW-1:0]    rd_ptr_r;
   logic [AW:0]      count_r;
   logic [AW:0]      count_nxt;
   logic             push;
   logic             pop;

   // Flags are flops so the ready port is registered
   assign push          = in_valid_in && in_ready_out;
   assign pop           = out_valid_out && out_ready_in;
   assign out_data_out  = mem_r[rd_ptr_r];
   assign count_nxt     = count_r + (AW+1)'(push) - (AW+1)'(pop);

   // Storage, no reset needed
   always_ff @(posedge core_clk_in)
   begin
      if (push)
      begin
         mem_r[wr_ptr_r] <= in_data_in;
      end
   end

   // Pointers and occupancy
   always_ff @(posedge core_clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         wr_ptr_r      <= '0;
         rd_ptr_r      <= '0;
         count_r       <= '0;
         in_ready_out  <= 1'b0;
         out_valid_out <= 1'b0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
         end
         if (pop)
         begin
            rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
         end
         count_r       <= count_nxt;
         in_ready_out  <= (count_nxt != (AW+1)'(DEPTH));
         out_valid_out <= (count_nxt != '0);
      end
   end

endmodule

`default_nettype wire

// [wbl_dither.sv]
// Post-table dither: reduces each corrected 8-bit colour to 6 bits by
// carrying the dropped low bits into the next pixel of the same colour.
// Assumes advance_in marks each pixel that really moves to the output.
`default_nettype none

module wbl_dither
   import wbl_pkg::*;
(
   input  wire logic             core_clk_in,
   input  wire logic             rst_b_in,
   input  wire logic             enable_in,
   input  wire logic             advance_in,
   input  wire logic [PIX_W-1:0] pix_in,
   output logic      [PIX_W-1:0] pix_out
);

   localparam int ERR_W = SUB_W - DITH_W;

   // One error accumulator per colour lane
   for (genvar c = 0; c < COLOURS; c++)
   begin : g_lane
      logic [ERR_W-1:0] err_r;
      logic [SUB_W:0]   sum;
      logic [SUB_W-1:0] lane;

      assign lane = pix_in[c*SUB_W +: SUB_W];
      assign sum  = {1'b0, lane} + {{(SUB_W+1-ERR_W){1'b0}}, err_r};

      // Saturate at full scale, low bits forced to zero
      assign pix_out[c*SUB_W +: SUB_W] = !enable_in ? lane :
         sum[SUB_W] ? {{DITH_W{1'b1}}, {ERR_W{1'b0}}} :
         {sum[SUB_W-1:ERR_W], {ERR_W{1'b0}}};

      always_ff @(posedge core_clk_in or negedge rst_b_in)
      begin
         if (!rst_b_in)
         begin
            err_r <= '0;
         end
         else if (advance_in)
         begin
            err_r <= enable_in ? sum[ERR_W-1:0] : '0;
         end
      end
   end

endmodule

`default_nettype wire

// [wbl_white_balance.sv]
// Colour table stage: two-wire slave, paged control register, three
// 256-entry tables, pixel FIFO, lookup and post-table dither.
// Assumes SCL and SDA are already synchronous to core_clk_in and that the
// outside wire resolves the open-drain SDA from sda_oe_b_out.
//
// Summary of operation
// - Three tables, red green blue, each 256 entries of 8 bits.
// - When enabled, each subpixel is replaced by its own colour's entry.
// - Every table entry is writable and reads back the last stored byte.
// - Tables and control reached only as a slave on the two-wire bus.
// - 24-bit input to 24-bit panel passes full corrected 8 bits with post-table dither off.
// - Page field bits 7:6 of 0x2A select config, red, green, blue.
// - On a table page, addresses 0 to 255 map to that table's entries.
// - Control bit 5 enables correction; control resets to 0x00.
// - Without reload permission, tables are locked after the initial load.
// - Reload bit 4 allows rewrites while enabled, output continues uninterrupted.
// - Reload accepts any subset of entries.
// - Dither stage follows the tables and works on corrected data.
`default_nettype none

module wbl_white_balance
   import wbl_pkg::*;
(
   input  wire logic             core_clk_in,
   input  wire logic             rst_b_in,
   // Two-wire serial control
   input  wire logic             scl_in,
   input  wire logic             sda_in,
   output logic                  sda_out,
   output logic                  sda_oe_b_out,
   // Post-table dither enable, from outside configuration
   input  wire logic             post_lut_dither_en_in,
   // Incoming pixels
   input  wire logic             pix_valid_in,
   input  wire logic [PIX_W-1:0] pix_data_in,
   output logic                  pix_ready_out,
   // Outgoing pixels
   output logic                  pix_valid_out,
   output logic      [PIX_W-1:0] pix_data_out,
   input  wire logic             pix_ready_in,
   // Visible control state
   output logic                  wb_enable_out,
   output logic                  init_done_out
);

   // Tables: undefined after reset, never cleared
   logic [SUB_W-1:0] lut_r [COLOURS][LUT_DEPTH];

   logic [7:0]       ctrl_r;
   logic             init_done_r;
   wbl_i2c_state_t   state_r;
   logic [3:0]       bit_cnt_r;
   logic [7:0]       shift_r;
   logic [7:0]       tx_r;
   logic [7:0]       reg_addr_r;
   logic             rw_r;
   logic             alt_sel_r;
   logic             acked_r;
   logic             scl_q_r;
   logic             sda_q_r;
   logic             sda_oe_b_r;

   logic             scl_rise;
   logic             scl_fall;
   logic             start_det;
   logic             stop_det;
   logic             wr_stb;
   logic [1:0]       page_now;
   logic             tbl_wr_ok;
   logic [7:0]       rd_byte;

   logic             fifo_valid;
   logic [PIX_W-1:0] fifo_data;
   logic             advance;
   logic [PIX_W-1:0] corrected;
   logic [PIX_W-1:0] dithered;
   logic             out_valid_r;
   logic [PIX_W-1:0] out_data_r;

   // Bus edge and condition detection on the previous sample
   assign scl_rise  = scl_in && !scl_q_r;
   assign scl_fall  = !scl_in && scl_q_r;
   assign start_det = scl_in && scl_q_r && sda_q_r && !sda_in;
   assign stop_det  = scl_in && scl_q_r && !sda_q_r && sda_in;

   // The alternate address always sees the config page, so the host can
   // leave a table page without losing table location 0x2A
   assign page_now  = alt_sel_r ? PAGE_CFG : ctrl_r[PAGE_MSB:PAGE_LSB];
   assign wr_stb    = (state_r == ST_WDATA) && scl_fall && (bit_cnt_r == BITS_PER_BYTE);
   // Lock after the initial load unless reload is permitted
   assign tbl_wr_ok = !init_done_r || ctrl_r[RELOAD_BIT];

   // Read data for the current register address
   always_comb
   begin
      rd_byte = ZERO_BYTE;
      if (page_now == PAGE_CFG)
      begin
         if (reg_addr_r == CTRL_ADDR)
         begin
            rd_byte = ctrl_r & CTRL_WMASK;
         end
      end
      else
      begin
         rd_byte = lut_r[page_now - 2'h1][reg_addr_r];
      end
   end

   // Previous samples of the two wires
   always_ff @(posedge core_clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         scl_q_r <= 1'b1;
         sda_q_r <= 1'b1;
      end
      else
      begin
         scl_q_r <= scl_in;
         sda_q_r <= sda_in;
      end
   end

   // Slave-only protocol engine: never drives SCL
   always_ff @(posedge core_clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         state_r    <= ST_IDLE;
         bit_cnt_r  <= '0;
         shift_r    <= ZERO_BYTE;
         tx_r       <= ZERO_BYTE;
         reg_addr_r <= ZERO_BYTE;
         rw_r       <= 1'b0;
         alt_sel_r  <= 1'b0;
         acked_r    <= 1'b0;
         sda_oe_b_r <= 1'b1;
      end
      else if (start_det)
      begin
         state_r    <= ST_ADDR;
         bit_cnt_r  <= '0;
         sda_oe_b_r <= 1'b1;
      end
      else if (stop_det)
      begin
         state_r    <= ST_IDLE;
         sda_oe_b_r <= 1'b1;
      end
      else
      begin
         if (scl_rise)
         begin
            shift_r   <= {shift_r[6:0], sda_in};
            bit_cnt_r <= bit_cnt_r + 4'h1;
            if (state_r == ST_RDAT_ACK)
            begin
               acked_r   <= !sda_in;
               bit_cnt_r <= '0;
               if (!sda_in)
               begin
                  reg_addr_r <= reg_addr_r + 8'h01;
               end
            end
         end
         if (scl_fall)
         begin
            unique case (state_r)
               ST_IDLE: ;
               ST_ADDR:
                  if (bit_cnt_r == BITS_PER_BYTE)
                  begin
                     if (shift_r[7:1] == DEV_ADDR || shift_r[7:1] == CFG_ALT_ADDR)
                     begin
                        state_r    <= ST_ADDR_ACK;
                        rw_r       <= shift_r[0];
                        alt_sel_r  <= (shift_r[7:1] == CFG_ALT_ADDR);
                        sda_oe_b_r <= 1'b0;
                     end
                     else
                     begin
                        state_r <= ST_IDLE;
                     end
                  end
               ST_ADDR_ACK:
               begin
                  bit_cnt_r <= '0;
                  if (rw_r)
                  begin
                     state_r    <= ST_RDATA;
                     tx_r       <= {rd_byte[6:0], 1'b0};
                     sda_oe_b_r <= rd_byte[7];
                  end
                  else
                  begin
                     state_r    <= ST_REG;
                     sda_oe_b_r <= 1'b1;
                  end
               end
               ST_REG:
                  if (bit_cnt_r == BITS_PER_BYTE)
                  begin
                     reg_addr_r <= shift_r;
                     state_r    <= ST_REG_ACK;
                     sda_oe_b_r <= 1'b0;
                  end
               ST_REG_ACK, ST_WDAT_ACK:
               begin
                  state_r    <= ST_WDATA;
                  bit_cnt_r  <= '0;
                  sda_oe_b_r <= 1'b1;
               end
               ST_WDATA:
                  if (bit_cnt_r == BITS_PER_BYTE)
                  begin
                     state_r    <= ST_WDAT_ACK;
                     sda_oe_b_r <= 1'b0;
                     reg_addr_r <= reg_addr_r + 8'h01; // Auto-increment
                  end
               ST_RDATA:
                  if (bit_cnt_r == BITS_PER_BYTE)
                  begin
                     state_r    <= ST_RDAT_ACK;
                     sda_oe_b_r <= 1'b1;
                  end
                  else
                  begin
                     tx_r       <= {tx_r[6:0], 1'b0};
                     sda_oe_b_r <= tx_r[7];
                  end
               ST_RDAT_ACK:
                  if (acked_r)
                  begin
                     state_r    <= ST_RDATA;
                     tx_r       <= {rd_byte[6:0], 1'b0};
                     sda_oe_b_r <= rd_byte[7];
                  end
                  else
                  begin
                     state_r <= ST_IDLE; // Master ended the read
                  end
            endcase
         end
      end
   end

   // Control register, page and enable fields
   always_ff @(posedge core_clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         ctrl_r <= CTRL_RST;
      end
      else if (wr_stb && page_now == PAGE_CFG && reg_addr_r == CTRL_ADDR)
      begin
         ctrl_r <= shift_r & CTRL_WMASK; // Low bits reserved, read zero
      end
   end

   // Initial load ends when the host first sets the enable
   always_ff @(posedge core_clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         init_done_r <= 1'b0;
      end
      else if (ctrl_r[EN_BIT])
      begin
         init_done_r <= 1'b1;
      end
   end

   // Table write ports and pixel lookups, one per colour
   for (genvar c = 0; c < COLOURS; c++)
   begin : g_colour
      localparam int LANE = (COLOURS - 1 - c) * SUB_W;
      logic [SUB_W-1:0] sub_in;

      assign sub_in = fifo_data[LANE +: SUB_W];

      // Single-entry writes, so reloads may touch any subset
      always_ff @(posedge core_clk_in)
      begin
         if (wr_stb && tbl_wr_ok && page_now == 2'(c + 1))
         begin
            lut_r[c][reg_addr_r] <= shift_r;
         end
      end

      // Replace or pass each subpixel
      assign corrected[LANE +: SUB_W] = ctrl_r[EN_BIT] ? lut_r[c][sub_in] : sub_in;
   end

   // Input buffer absorbs bursts while the panel side stalls
   wbl_fifo #(
      .WIDTH (PIX_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .core_clk_in   (core_clk_in),
      .rst_b_in      (rst_b_in),
      .in_valid_in   (pix_valid_in),
      .in_data_in    (pix_data_in),
      .in_ready_out  (pix_ready_out),
      .out_valid_out (fifo_valid),
      .out_data_out  (fifo_data),
      .out_ready_in  (advance)
   );

   // Output register moves when empty or when the panel accepts
   assign advance = !out_valid_r || pix_ready_in;

   // Dither sits after the tables, on corrected data
   wbl_dither u_post_lut_dither (
      .core_clk_in (core_clk_in),
      .rst_b_in    (rst_b_in),
      .enable_in   (post_lut_dither_en_in),
      .advance_in  (advance && fifo_valid),
      .pix_in      (corrected),
      .pix_out     (dithered)
   );

   // Output pixel register; table rewrites never stall it
   always_ff @(posedge core_clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         out_valid_r <= 1'b0;
         out_data_r  <= '0;
      end
      else if (advance)
      begin
         out_valid_r <= fifo_valid;
         out_data_r  <= dithered;
      end
   end

   // Ports from flops, except sda_out tied low
   assign pix_valid_out = out_valid_r;
   assign pix_data_out  = out_data_r;
   assign sda_out       = 1'b0;
   assign sda_oe_b_out  = sda_oe_b_r;
   assign wb_enable_out = ctrl_r[EN_BIT];
   assign init_done_out = init_done_r;

endmodule

`default_nettype wire

// [wbl_white_balance_asserts.sv]
// Checker for the colour table stage, watching only its top-level ports.
// Assumes SCL arrives already synchronous to core_clk_in.
`default_nettype none

module wbl_white_balance_asserts
   import wbl_pkg::*;
(
   input wire logic             core_clk_in,
   input wire logic             rst_b_in,
   input wire logic             scl_in,
   input wire logic             sda_in,
   input wire logic             sda_out,
   input wire logic             sda_oe_b_out,
   input wire logic             post_lut_dither_en_in,
   input wire logic             pix_valid_out,
   input wire logic [PIX_W-1:0] pix_data_out,
   input wire logic             pix_ready_in,
   input wire logic             wb_enable_out,
   input wire logic             init_done_out
);
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!rst_b_in);

   // SCL low now and one sample before: the only safe time to move SDA
   sequence s_scl_low;
      !scl_in && !$past(scl_in);
   endsequence

   // Panel holding off a waiting pixel
   sequence s_stalled;
      pix_valid_out && !pix_ready_in;
   endsequence

   // Dither on long enough that no older pixel is still in flight
   sequence s_dither_settled;
      post_lut_dither_en_in [*8] ##0 pix_valid_out;
   endsequence

   a_reset_state_clear: assert property ($rose(rst_b_in) |-> !wb_enable_out && !init_done_out && sda_oe_b_out)
      else $error("control state not clear after reset");
   a_enable_on_low: assert property ($changed(wb_enable_out) |-> s_scl_low)
      else $error("enable moved outside a byte end");
   a_init_after_enable: assert property ($rose(wb_enable_out) |=> init_done_out)
      else $error("load lock not set after enable");
   a_init_needs_enable: assert property ($rose(init_done_out) |-> $past(wb_enable_out))
      else $error("load lock set without enable");
   a_init_stays_set: assert property (init_done_out |=> init_done_out)
      else $error("load lock dropped");
   a_sda_on_low: assert property ($changed(sda_oe_b_out) |-> s_scl_low)
      else $error("SDA moved while SCL high");
   a_stop_releases_sda: assert property (scl_in && $past(scl_in) && !$past(sda_in) && sda_in |=> sda_oe_b_out)
      else $error("SDA still held after STOP");
   a_stall_holds: assert property (s_stalled |=> pix_valid_out && $stable(pix_data_out))
      else $error("stalled pixel lost or changed");
   a_dither_low_zero: assert property (s_dither_settled |-> (pix_data_out & 24'h030303) == 24'h000000)
      else $error("dithered pixel has low bits set");
endmodule

bind wbl_white_balance wbl_white_balance_asserts i_chk (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in),
   .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_b_out(sda_oe_b_out),
   .post_lut_dither_en_in(post_lut_dither_en_in), .pix_valid_out(pix_valid_out),
   .pix_data_out(pix_data_out), .pix_ready_in(pix_ready_in), .wb_enable_out(wb_enable_out),
   .init_done_out(init_done_out));

`default_nettype wire

// [wbl_host_model.sv]
// Two-wire host model: owns SCL, shares SDA, loads and reads the tables.
// Assumes a pull-up on SDA; the stage only pulls low through its enable.
`default_nettype none

module wbl_host_model
   import wbl_pkg::*;
(
   input  wire logic core_clk_in,
   input  wire logic sda_oe_b_in,
   input  wire logic sda_drv_in,
   output logic      scl_out,
   output logic      sda_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic scl_r = 1'b1;
   logic sda_r = 1'b1;
   int   nacks = 0;

   // Wired-AND with pull-up: a released line reads high
   assign sda_out = sda_r & (sda_oe_b_in | sda_drv_in);
   assign scl_out = scl_r;

   // Odd step keeps every entry of a table unique
   function automatic logic [7:0] entry(input int c, input int i);
      return 8'(i * 5 + c * 77 + 3);
   endfunction

   task automatic tick(input int n);
      repeat (n) @(posedge core_clk_in);
   endtask

   // SDA moves only a clock after SCL fell, so no false START or STOP
   task automatic bit_io(input logic b, output logic r);
      sda_r <= b;
      tick(2);
      scl_r <= 1'b1;
      tick(2);
      r = sda_out;
      scl_r <= 1'b0;
      tick(1);
   endtask

   task automatic start();
      sda_r <= 1'b1;
      tick(3);
      scl_r <= 1'b1;
      tick(2);
      sda_r <= 1'b0;
      tick(2);
      scl_r <= 1'b0;
      tick(1);
   endtask

   task automatic stop();
      sda_r <= 1'b0;
      tick(2);
      scl_r <= 1'b1;
      tick(2);
      sda_r <= 1'b1;
      tick(2);
   endtask

   task automatic put(input logic [7:0] b);
      logic r;
      for (int k = 7; k >= 0; k--)
         bit_io(b[k], r);
      bit_io(1'b1, r);
      if (r !== 1'b0)
         nacks++;
   endtask

   task automatic get(output logic [7:0] b);
      logic r;
      for (int k = 7; k >= 0; k--)
         bit_io(1'b1, b[k]);
      bit_io(1'b1, r);
   endtask

   task automatic wr(input logic [6:0] dev, input logic [7:0] adr, input logic [7:0] d);
      start();
      put({dev, 1'b0});
      put(adr);
      put(d);
      stop();
   endtask

   task automatic rd(input logic [6:0] dev, input logic [7:0] adr, output logic [7:0] d);
      start();
      put({dev, 1'b0});
      put(adr);
      start();
      put({dev, 1'b1});
      get(d);
      stop();
   endtask

   // Initial load: red, green, blue in turn, all entries, then enable
   task automatic load(input logic six);
      for (int c = 0; c < COLOURS; c++)
      begin
         wr(CFG_ALT_ADDR, CTRL_ADDR, {2'(c + 1), 6'h00});
         start();
         put({DEV_ADDR, 1'b0});
         put(ZERO_BYTE);
         for (int i = 0; i < LUT_DEPTH; i++)
            put(entry(c, i) & (six ? 8'hfc : 8'hff));
         stop();
      end
      wr(CFG_ALT_ADDR, CTRL_ADDR, 8'h20);
   endtask
endmodule

`default_nettype wire

// [wbl_white_balance_test.sv]
// Self-checking bench for the colour table stage: bus, tables, pixels.
// Assumes the host model owns SCL/SDA and the bench owns the pixel ports.
`default_nettype none

module wbl_white_balance_test
   import wbl_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ns;
   logic             clk = 1'b0;
   logic             rst_b = 1'b0;
   logic             dith_en = 1'b0;
   logic             pv_in = 1'b0;
   logic [PIX_W-1:0] pd_in = 24'h000000;
   logic             prdy_in = 1'b0;
   wire logic        scl, sda, oe_b, sda_o, prdy_out, pv_out, en_out, init_out;
   wire logic [PIX_W-1:0] pd_out;
   int               error_cnt = 0;
   int               checked = 0;
   logic [7:0]       rb;
   logic [7:0]       tab [3][256];
   logic             en_exp = 1'b0;

   always #25 clk = ~clk;

   wbl_white_balance i_dut (.core_clk_in(clk), .rst_b_in(rst_b), .scl_in(scl), .sda_in(sda),
      .sda_out(sda_o), .sda_oe_b_out(oe_b), .post_lut_dither_en_in(dith_en), .pix_valid_in(pv_in),
      .pix_data_in(pd_in), .pix_ready_out(prdy_out), .pix_valid_out(pv_out), .pix_data_out(pd_out),
      .pix_ready_in(prdy_in), .wb_enable_out(en_out), .init_done_out(init_out));
   wbl_host_model i_host (.core_clk_in(clk), .sda_oe_b_in(oe_b), .sda_drv_in(sda_o), .scl_out(scl),
      .sda_out(sda));

   task automatic end_of_test();
      $display("checked=%0d error_cnt=%0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic timeout();
      error_cnt++;
      $display("ERROR t=%0t wait limit used up", $time);
      end_of_test();
   endtask

   task automatic cmp_pix(input logic [23:0] got, input logic [23:0] exp);
      checked++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp);
      cmp_pix({16'h0000, got}, {16'h0000, exp});
   endtask

   task automatic cmp_flag(input logic got, input logic exp);
      cmp_pix({23'h000000, got}, {23'h000000, exp});
   endtask

   // Lookup when enabled, plain copy otherwise
   function automatic logic [23:0] expect_pix(input logic [23:0] p);
      if (!en_exp)
         return p;
      return {tab[0][p[23:16]], tab[1][p[15:8]], tab[2][p[7:0]]};
   endfunction

   // Panel stalls 25 clocks so the FIFO must refuse, then takes every other clock
   task automatic stream(input int n, input logic [23:0] base, input logic [23:0] mask);
      logic [23:0] q[$];
      logic [23:0] p;
      logic        full;
      int          got;
      full = 1'b0;
      got = 0;
      fork
         for (int i = 0; i < n; i++)
         begin
            p = base + 24'(i) * 24'h0b0503;
            pv_in <= 1'b1;
            pd_in <= p;
            q.push_back(expect_pix(p));
            @(posedge clk);
            for (int k = 0; k < 99 && prdy_out !== 1'b1; k++)
            begin
               full = 1'b1;
               @(posedge clk);
            end
            if (prdy_out !== 1'b1)
               timeout();
            if (i == n - 1)
               pv_in <= 1'b0;
         end
         for (int k = 0; got < n; k++)
         begin
            @(posedge clk);
            if (pv_out === 1'b1 && prdy_in === 1'b1)
            begin
               cmp_pix(pd_out & mask, q.pop_front() & mask & {24{!dith_en}});
               got++;
            end
            prdy_in <= k > 24 && k[0];
            if (k > 3000)
               timeout();
         end
      join
      cmp_flag(full, 1'b1);
   endtask

   task automatic t_regs();
      i_host.rd(DEV_ADDR, CTRL_ADDR, rb);
      cmp_reg(rb, CTRL_RST);
      i_host.wr(CFG_ALT_ADDR, CTRL_ADDR, 8'h0f);
      i_host.rd(CFG_ALT_ADDR, CTRL_ADDR, rb);
      cmp_reg(rb, 8'h00);
      i_host.wr(DEV_ADDR, 8'h10, 8'h5a);
      i_host.rd(DEV_ADDR, 8'h10, rb);
      cmp_reg(rb, ZERO_BYTE);
      i_host.wr(7'h30, CTRL_ADDR, 8'h20);
      cmp_flag(en_out, 1'b0);
      cmp_reg(8'(i_host.nacks), 8'h03);
   endtask

   task automatic t_bypass();
      stream(16, 24'h01fe7f, 24'hffffff);
      cmp_flag(init_out, 1'b0);
   endtask

   task automatic t_load();
      i_host.load(1'b0);
      for (int c = 0; c < COLOURS; c++)
         for (int i = 0; i < LUT_DEPTH; i++)
            tab[c][i] = i_host.entry(c, i);
      cmp_flag(en_out, 1'b1);
      cmp_flag(init_out, 1'b1);
      // End entries of every page read back through the window
      for (int c = 0; c < COLOURS; c++)
      begin
         i_host.wr(CFG_ALT_ADDR, CTRL_ADDR, {2'(c + 1), 6'h20});
         i_host.rd(DEV_ADDR, 8'hff, rb);
         cmp_reg(rb, tab[c][255]);
         i_host.rd(DEV_ADDR, 8'h00, rb);
         cmp_reg(rb, tab[c][0]);
      end
      en_exp = 1'b1;
   endtask

   task automatic t_lookup();
      stream(16, 24'hff00fe, 24'hffffff);
   endtask

   task automatic t_locked();
      i_host.wr(CFG_ALT_ADDR, CTRL_ADDR, 8'h60);
      i_host.wr(DEV_ADDR, 8'h05, ~tab[0][5]);
      i_host.rd(DEV_ADDR, 8'h05, rb);
      cmp_reg(rb, tab[0][5]);
   endtask

   task automatic t_reload();
      i_host.wr(CFG_ALT_ADDR, CTRL_ADDR, 8'hb0);
      i_host.wr(DEV_ADDR, 8'h40, 8'h99);
      tab[1][8'h40] = 8'h99;
      i_host.wr(CFG_ALT_ADDR, CTRL_ADDR, 8'hf0);
      i_host.wr(DEV_ADDR, 8'h41, 8'h12);
      tab[2][8'h41] = 8'h12;
      i_host.rd(DEV_ADDR, 8'h41, rb);
      cmp_reg(rb, 8'h12);
      cmp_flag(en_out, 1'b1);
      stream(12, 24'h004041, 24'hffffff);
   endtask

   task automatic t_dither();
      dith_en <= 1'b1;
      repeat (10) @(posedge clk);
      stream(12, 24'h7f8081, 24'h030303);
      dith_en <= 1'b0;
      repeat (10) @(posedge clk);
   endtask

   task automatic t_disable();
      i_host.wr(CFG_ALT_ADDR, CTRL_ADDR, 8'h00);
      en_exp = 1'b0;
      cmp_flag(en_out, 1'b0);
      cmp_flag(init_out, 1'b1);
      stream(12, 24'h004041, 24'hffffff);
   endtask

   // Reset held 12 clocks, then scenarios in order
   initial
   begin
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      t_regs();
      t_bypass();
      t_load();
      t_lookup();
      t_locked();
      t_reload();
      t_dither();
      t_disable();
      end_of_test();
   end
endmodule

`default_nettype wire
